// [core/cspm_pkg.sv]
// Notes on behaviour
// - Clock stopped or slowed only while card idle
// - Card access sets socket access flag bit 25
// - Reading register clears socket access flag
// - Clock mode flag shows changed clock frequency
// - Idle select acts only when enable set
// - Clock select enable resets to zero
// - Select zero lets protocol stop clock
// - Select one slows clock by sixteen
// - Reserved bits always read as zero
// - Register at 20h, resets to zero
// - Policy clear also needs host clock-stop
package cspm_pkg;
    localparam logic [7:0] PM_OFFSET = 8'h20;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h24;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h28;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h2C;
    localparam logic [7:0] POLICY_OFFSET = 8'h30;
    localparam int ACCESS_BIT = 25;
    localparam int MODE_BIT = 24;
    localparam int SEL_EN_BIT = 16;
    localparam int SEL_BIT = 0;
    localparam logic [31:0] PM_RESET = 32'h00000000;
    localparam int SLOW_DIV = 16;
    localparam logic [3:0] DIV_LAST = 4'hF;
    localparam int IRQ_ACCESS = 0;
    localparam int IRQ_MODE_UP = 1;
    localparam int IRQ_MODE_DOWN = 2;
    typedef enum logic [2:0] {
        CSPM_RUN = 3'b001,
        CSPM_STOP = 3'b010,
        CSPM_SLOW = 3'b100
    } cspm_clk_e;
endpackage

// [core/cspm_ctrl.sv]
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module cspm_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_access,
    input wire logic card_idle,
    input wire logic host_clk_stop_req,
    output logic card_clk_en,
    output logic card_clk_mode_stop,
    output logic card_clk_mode_slow,
    output logic irq
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic acc_prev_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            acc_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= {host_clk_stop_req, card_idle, card_access};
            sync2_ff <= sync1_ff;
            acc_prev_ff <= sync2_ff[0];
        end
    end
    logic acc_ev;
    logic idle_s;
    logic host_stop_s;
    assign acc_ev = sync2_ff[0] & ~acc_prev_ff;
    assign idle_s = sync2_ff[1];
    assign host_stop_s = sync2_ff[2];

    // ************************************************************
    // APB slave
    // ************************************************************
    logic wr_en;
    logic rd_en;
    logic known;
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign known = (paddr == cspm_pkg::PM_OFFSET) || (paddr == cspm_pkg::IRQ_STATUS_OFFSET)
        || (paddr == cspm_pkg::IRQ_ENABLE_OFFSET) || (paddr == cspm_pkg::IRQ_CLEAR_OFFSET)
        || (paddr == cspm_pkg::POLICY_OFFSET);
    assign pslverr = psel & penable & ~known;

    logic sel_en_ff;
    logic sel_ff;
    logic policy_ff;
    logic access_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_en_ff;
    cspm_pkg::cspm_clk_e state_ff;
    logic mode_flag;
    logic pm_rd;
    assign pm_rd = rd_en && paddr == cspm_pkg::PM_OFFSET;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_en_ff <= 1'b0;
            sel_ff <= 1'b0;
            policy_ff <= 1'b0;
        end else if (wr_en && paddr == cspm_pkg::PM_OFFSET) begin
            sel_en_ff <= pwdata[cspm_pkg::SEL_EN_BIT];
            sel_ff <= pwdata[cspm_pkg::SEL_BIT];
        end else if (wr_en && paddr == cspm_pkg::POLICY_OFFSET) begin
            policy_ff <= pwdata[0];
        end
    end

    // Set wins over the read clear, so a coincident access is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_ff <= 1'b0;
        end else if (acc_ev) begin
            access_ff <= 1'b1;
        end else if (pm_rd) begin
            access_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            case (paddr)
                cspm_pkg::PM_OFFSET: begin
                    prdata[cspm_pkg::ACCESS_BIT] <= access_ff | acc_ev;
                    prdata[cspm_pkg::MODE_BIT] <= mode_flag;
                    prdata[cspm_pkg::SEL_EN_BIT] <= sel_en_ff;
                    prdata[cspm_pkg::SEL_BIT] <= sel_ff;
                end
                cspm_pkg::IRQ_STATUS_OFFSET: prdata[2:0] <= irq_stat_ff;
                cspm_pkg::IRQ_ENABLE_OFFSET: prdata[2:0] <= irq_en_ff;
                cspm_pkg::POLICY_OFFSET: prdata[0] <= policy_ff;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ************************************************************
    // Card clock control
    // ************************************************************
    logic may_idle;
    logic slow_sel;
    assign may_idle = idle_s & (policy_ff | host_stop_s);
    assign slow_sel = sel_en_ff & sel_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= cspm_pkg::CSPM_RUN;
        end else begin
            case (state_ff)
                cspm_pkg::CSPM_RUN: begin
                    if (may_idle) begin
                        state_ff <= slow_sel ? cspm_pkg::CSPM_SLOW
                                             : cspm_pkg::CSPM_STOP;
                    end
                end
                cspm_pkg::CSPM_STOP, cspm_pkg::CSPM_SLOW: begin
                    if (!may_idle) begin
                        state_ff <= cspm_pkg::CSPM_RUN;
                    end
                end
                default: state_ff <= cspm_pkg::CSPM_RUN;
            endcase
        end
    end
    assign mode_flag = state_ff != cspm_pkg::CSPM_RUN;

    // Slow mode passes one clock enable in sixteen
    logic [3:0] div_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 4'h0;
        end else if (state_ff == cspm_pkg::CSPM_SLOW) begin
            div_ff <= div_ff + 4'h1;
        end else begin
            div_ff <= 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_clk_en <= 1'b1;
            card_clk_mode_stop <= 1'b0;
            card_clk_mode_slow <= 1'b0;
        end else begin
            case (state_ff)
                cspm_pkg::CSPM_STOP: card_clk_en <= 1'b0;
                cspm_pkg::CSPM_SLOW: card_clk_en <= (div_ff == cspm_pkg::DIV_LAST);
                default: card_clk_en <= 1'b1;
            endcase
            card_clk_mode_stop <= state_ff == cspm_pkg::CSPM_STOP;
            card_clk_mode_slow <= state_ff == cspm_pkg::CSPM_SLOW;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic mode_prev_ff;
    logic [2:0] ev;
    logic [2:0] clr;
    assign ev = {mode_prev_ff & ~mode_flag, ~mode_prev_ff & mode_flag, acc_ev};
    assign clr = (wr_en && paddr == cspm_pkg::IRQ_CLEAR_OFFSET) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_prev_ff <= 1'b0;
            irq_stat_ff <= 3'h0;
            irq_en_ff <= 3'h0;
        end else begin
            mode_prev_ff <= mode_flag;
            irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
            if (wr_en && paddr == cspm_pkg::IRQ_ENABLE_OFFSET) begin
                irq_en_ff <= pwdata[2:0];
            end
        end
    end
    assign irq = |(irq_stat_ff & irq_en_ff);

    // ************************************************************
    // Checks
    // ************************************************************
    property p_access_set;
        @(posedge pclk) disable iff (!presetn) acc_ev |=> access_ff;
    endproperty
    a_access_set: assert property (p_access_set) else $error("access flag not set");
    property p_access_clr;
        @(posedge pclk) disable iff (!presetn) (pm_rd && !acc_ev) |=> !access_ff;
    endproperty
    a_access_clr: assert property (p_access_clr) else $error("access flag not cleared");
    property p_en_reset;
        @(posedge pclk) $rose(presetn) |-> !sel_en_ff;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable not zero at reset");
    property p_only_idle;
        @(posedge pclk) disable iff (!presetn)
            (state_ff == cspm_pkg::CSPM_RUN && !may_idle) |=> state_ff == cspm_pkg::CSPM_RUN;
    endproperty
    a_only_idle: assert property (p_only_idle) else $error("clock changed while busy");
    property p_stop;
        @(posedge pclk) disable iff (!presetn)
            (state_ff == cspm_pkg::CSPM_RUN && may_idle && !slow_sel)
            |=> state_ff == cspm_pkg::CSPM_STOP ##1 !card_clk_en;
    endproperty
    a_stop: assert property (p_stop) else $error("clock not stopped");
    sequence s_slow_entry;
        state_ff == cspm_pkg::CSPM_RUN && may_idle && slow_sel;
    endsequence
    property p_slow;
        @(posedge pclk) disable iff (!presetn) s_slow_entry |=> state_ff == cspm_pkg::CSPM_SLOW;
    endproperty
    a_slow: assert property (p_slow) else $error("clock not slowed");
    // Helper count of low enable cycles; a deep repetition would choke the tools
    logic [4:0] gap_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff <= 5'h00;
        end else if (card_clk_en || !card_clk_mode_slow) begin
            gap_ff <= 5'h00;
        end else begin
            gap_ff <= gap_ff + 5'h01;
        end
    end
    property p_slow_gap;
        @(posedge pclk) disable iff (!presetn)
            (state_ff == cspm_pkg::CSPM_SLOW && card_clk_mode_slow
                && gap_ff != 5'(cspm_pkg::SLOW_DIV - 2)) |=> !card_clk_en;
    endproperty
    a_slow_gap: assert property (p_slow_gap) else $error("slow enable too dense");
    property p_slow_beat;
        @(posedge pclk) disable iff (!presetn)
            (state_ff == cspm_pkg::CSPM_SLOW && card_clk_mode_slow && !card_clk_en
                && gap_ff == 5'(cspm_pkg::SLOW_DIV - 2)) |=> card_clk_en;
    endproperty
    a_slow_beat: assert property (p_slow_beat) else $error("slow enable missing");
    property p_sel_gate;
        @(posedge pclk) disable iff (!presetn)
            !sel_en_ff && state_ff == cspm_pkg::CSPM_RUN |=> state_ff != cspm_pkg::CSPM_SLOW;
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("select used while disabled");
    property p_policy;
        @(posedge pclk) disable iff (!presetn)
            (state_ff == cspm_pkg::CSPM_RUN && !policy_ff && !host_stop_s)
            |=> state_ff == cspm_pkg::CSPM_RUN;
    endproperty
    a_policy: assert property (p_policy) else $error("idle without host stop");
    property p_restore;
        @(posedge pclk) disable iff (!presetn)
            (state_ff != cspm_pkg::CSPM_RUN && !may_idle) |=> !mode_flag;
    endproperty
    a_restore: assert property (p_restore) else $error("mode flag stuck");
    property p_rsvd;
        @(posedge pclk) disable iff (!presetn)
            (psel && !penable && !pwrite && paddr == cspm_pkg::PM_OFFSET)
            |=> (prdata & 32'hFCFEFFFE) == 32'h00000000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
    property p_rd_mode;
        @(posedge pclk) disable iff (!presetn)
            (psel && !penable && !pwrite && paddr == cspm_pkg::PM_OFFSET)
            |=> prdata[cspm_pkg::MODE_BIT] == ($past(state_ff) != cspm_pkg::CSPM_RUN);
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode flag misread");
    property p_acc_irq;
        @(posedge pclk) disable iff (!presetn) acc_ev |=> irq_stat_ff[cspm_pkg::IRQ_ACCESS];
    endproperty
    a_acc_irq: assert property (p_acc_irq) else $error("access event not latched");
    property p_mode_irq;
        @(posedge pclk) disable iff (!presetn)
            (!mode_prev_ff && mode_flag) |=> irq_stat_ff[cspm_pkg::IRQ_MODE_UP];
    endproperty
    a_mode_irq: assert property (p_mode_irq) else $error("mode event not latched");
    property p_reg_reset;
        @(posedge pclk) $rose(presetn)
            |-> !sel_ff && !access_ff && !policy_ff && state_ff == cspm_pkg::CSPM_RUN;
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("register not reset");
    property p_stop_gate;
        @(posedge pclk) disable iff (!presetn) card_clk_mode_stop |-> !card_clk_en;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("clock runs in stop");
    // Restore is two steps: state first, then the registered gate
    sequence s_idle_end;
        state_ff != cspm_pkg::CSPM_RUN && !may_idle;
    endsequence
    sequence s_clock_back;
        state_ff == cspm_pkg::CSPM_RUN ##1 card_clk_en;
    endsequence
    property p_resume;
        @(posedge pclk) disable iff (!presetn) s_idle_end |=> s_clock_back;
    endproperty
    a_resume: assert property (p_resume) else $error("clock not restored");
endmodule

// [testbench/cspm_card_model.sv]
`timescale 1ns/1ps
// ****
// Card side model
// ****
module cspm_card_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic busy_req,
    input wire logic access_req,
    output logic card_access,
    output logic card_idle
);
    // Pins come from the card's own flops; the block must resync them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_access <= 1'b0;
            card_idle <= 1'b0;
        end else begin
            card_access <= access_req;
            card_idle <= !busy_req;
        end
    end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, card_access, card_idle, clk_en, stop_o, slow_o, irq;
    logic host_req = 1'b0;
    logic busy = 1'b1;
    logic acc = 1'b0;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    always #5 pclk = ~pclk;
    cspm_ctrl cspm_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .card_access(card_access), .card_idle(card_idle),
        .host_clk_stop_req(host_req), .card_clk_en(clk_en), .card_clk_mode_stop(stop_o),
        .card_clk_mode_slow(slow_o), .irq(irq));
    cspm_card_model cspm_card_model_i (.pclk(pclk), .presetn(presetn), .busy_req(busy),
        .access_req(acc), .card_access(card_access), .card_idle(card_idle));
    // ****
    // Tasks
    // ****
    task print_verdict;
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask
    task settle;
        repeat (8) @(posedge pclk);
    endtask
    task pulse;
        @(posedge pclk);
        acc <= 1'b1;
        @(posedge pclk);
        acc <= 1'b0;
        settle();
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("clk_en_rst", 32'h1, clk_en);
        rdc(cspm_pkg::PM_OFFSET, 32'h00000000, "pm_reset");
        apb(1'b1, cspm_pkg::PM_OFFSET, 32'hFFFFFFFF);
        rdc(cspm_pkg::PM_OFFSET, 32'h00010001, "pm_rsvd");
        apb(1'b1, cspm_pkg::IRQ_ENABLE_OFFSET, 32'h00000001);
        pulse();
        chk("irq_acc", 32'h1, irq);
        rdc(cspm_pkg::PM_OFFSET, 32'h02010001, "acc_set");
        rdc(cspm_pkg::PM_OFFSET, 32'h00010001, "acc_clr");
        apb(1'b1, cspm_pkg::IRQ_ENABLE_OFFSET, 32'h00000000);
        pulse();
        chk("irq_mask", 32'h0, irq);
        apb(1'b1, cspm_pkg::IRQ_CLEAR_OFFSET, 32'h00000007);
        rdc(cspm_pkg::IRQ_STATUS_OFFSET, 32'h00000000, "irq_clr");
        rdc(8'h3C, 32'h00000000, "unmapped");
        chk("slverr", 32'h1, err);
        apb(1'b1, cspm_pkg::POLICY_OFFSET, 32'h00000001);
        busy <= 1'b0;
        settle();
        chk("slow", 32'h1, slow_o);
        n = 0;
        repeat (32) begin
            @(posedge pclk);
            n += (clk_en === 1'b1);
        end
        chk("slow_ticks", 32'd2, n);
        rdc(cspm_pkg::PM_OFFSET, 32'h03010001, "mode_chg");
        busy <= 1'b1;
        settle();
        rdc(cspm_pkg::PM_OFFSET, 32'h00010001, "mode_back");
        chk("clk_en_busy", 32'h1, clk_en);
        rdc(cspm_pkg::IRQ_STATUS_OFFSET, 32'h00000006, "irq_mode");
        apb(1'b1, cspm_pkg::PM_OFFSET, 32'h00000001);
        busy <= 1'b0;
        settle();
        chk("sel_gated", 32'h1, stop_o);
        chk("stop_en", 32'h0, clk_en);
        busy <= 1'b1;
        apb(1'b1, cspm_pkg::POLICY_OFFSET, 32'h00000000);
        busy <= 1'b0;
        settle();
        chk("no_host", 32'h0, stop_o);
        host_req <= 1'b1;
        settle();
        chk("host_stop", 32'h1, stop_o);
        apb(1'b1, cspm_pkg::PM_OFFSET, 32'h00010001);
        busy <= 1'b1;
        host_req <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(cspm_pkg::PM_OFFSET, 32'h00000000, "pm_rerst");
        chk("clk_en_rerst", 32'h1, clk_en);
        rdc(cspm_pkg::IRQ_STATUS_OFFSET, 32'h00000000, "irq_rerst");
        print_verdict();
    end
endmodule
